/* File: sssf_pkg.sv */
package sssf_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] SSF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] SSF_ADDR_CTRL   = 8'h04;
  localparam logic [7:0] SSF_ADDR_TXDATA = 8'h08;
  localparam logic [7:0] SSF_ADDR_RXDATA = 8'h0C;

  // ****************************************
  // status bit positions and reset values
  // ****************************************
  localparam int SSF_B_TXEMPTY = 7;
  localparam int SSF_B_RXFULL  = 6;
  localparam int SSF_B_OVERRUN = 5;
  localparam int SSF_B_FRAMING = 4;
  localparam int SSF_B_PARITY  = 3;
  localparam int SSF_B_TXEND   = 2;
  localparam int SSF_B_RXMP    = 1;
  localparam int SSF_B_TXMP    = 0;
  localparam logic [7:0] SSF_STATUS_RST = 8'h84;

  // ****************************************
  // control bit positions
  // ****************************************
  localparam int SSF_C_TXEN    = 0;
  localparam int SSF_C_RXEN    = 1;
  localparam int SSF_C_RXIRQEN = 2;
  localparam int SSF_C_MSTOP = 3;
  localparam logic [3:0] SSF_CTRL_RST = 4'h0;

  localparam int SSF_FIFO_DEPTH = 8;

  typedef struct packed {
    logic       mp_bit;
    logic       perr;
    logic       ferr;
    logic [7:0] data;
  } sssf_rxw_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} sssf_bus_st_t;
endpackage : sssf_pkg

/* File: sssf_sync3.sv */
`timescale 1ns/1ps
module sssf_sync3 (
  input  wire logic clk,   // clock
  input  wire logic rstn,  // async reset, low
  input  wire logic d,     // asynchronous level
  output logic      q      // filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // the level moves only once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
      q      <= 1'h0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) q <= s3_reg;
    end
  end
endmodule : sssf_sync3

/* File: sssf_fifo.sv */
`timescale 1ns/1ps
module sssf_fifo #(
  parameter int W = 8,  // word width
  parameter int D = 8   // depth, power of two
) (
  input  wire logic         clk,        // clock
  input  wire logic         rstn,       // async reset, low
  input  wire logic         in_valid,   // write request
  output logic              in_ready,   // not full
  input  wire logic [W-1:0] in_data,    // write word
  output logic              out_valid,  // not empty
  input  wire logic         out_ready,  // drain accepts
  output logic [W-1:0]      out_data    // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          rdy_reg;
  wire push = in_valid & rdy_reg;
  wire pop  = out_valid & out_ready;
  assign in_ready  = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'h1;
    end else begin
      wp_reg  <= wp_reg + AW'(push);
      rp_reg  <= rp_reg + AW'(pop);
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != (AW+1)'(D));
    end
  end
  // storage needs no reset; count guards every read
  always_ff @(posedge clk) begin
    if (push) mem[wp_reg] <= in_data;
  end
endmodule : sssf_fifo

/* File: sssf_core.sv */
// Functional notes
// - status is 8 bits, 84h after reset, standby or module stop
// - cpu may read or write status at any time
// - writing 1 to the five clearable flags is ignored; clear needs read-1 first
// - transmit end and received multiprocessor bit read-only; bit 0 read/write
// - buffer empty set while transmit disabled or on holding-to-shift move
// - buffer empty cleared by software clear or controller write to holding
// - buffer full set when a clean word enters the receive holding register
// - buffer full cleared by software clear or controller read of holding
// - reception error or receive disable leave holding and full flag alone
// - new word while full sets overrun and is discarded
// - overrun cleared by writing 0 after reading 1
// - with interrupt enable, full flag set raises receive interrupt
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sssf_core
  import sssf_pkg::*;
(
  input  wire logic        hclk,          // bus clock, 250 MHz
  input  wire logic        hresetn,       // async reset, low
  input  wire logic        hsel,          // slave select
  input  wire logic [31:0] haddr,         // address
  input  wire logic [1:0]  htrans,        // transfer type
  input  wire logic        hwrite,        // write
  input  wire logic [2:0]  hsize,         // size, word only
  input  wire logic        hready,        // bus ready
  input  wire logic [31:0] hwdata,        // write data
  output logic [31:0]      hrdata,        // read data
  output logic             hreadyout,     // slave ready
  output logic             hresp,         // always okay
  input  wire logic        standby_pin,   // standby request, async
  input  wire logic        tx_load,       // holding moved to shift reg
  input  wire logic        tx_end_in,     // transmitter idle level
  output logic [7:0]       tx_data_o,     // transmit holding register
  output logic             tx_pending_o,  // holding has data
  input  wire logic        xfer_tx_write, // controller writes holding
  input  wire logic [7:0]  xfer_tx_data,  // controller data
  input  wire logic        xfer_rx_read,  // controller reads holding
  input  wire logic        rx_valid,      // received word offered
  output logic             rx_ready,      // fifo can take word
  input  wire sssf_rxw_t   rx_word,       // word, errors, mp bit
  output logic [7:0]       rx_data_o,     // receive holding register
  output logic             rx_full_irq_o  // receive full request
);
  // ****************************************
  // registers
  // ****************************************
  sssf_bus_st_t st_reg;
  sssf_bus_st_t st_next;
  logic [7:0]   addr_reg;
  logic         wr_reg;
  logic [7:0]   stat_reg;
  logic [7:0]   stat_next;
  logic [4:0]   armed_reg;
  logic [4:0]   armed_next;
  logic [3:0]   ctrl_reg;
  logic [7:0]   tx_hold_reg;
  logic [7:0]   rx_hold_reg;
  logic         irq_reg;
  logic         pend_reg;
  logic [31:0]  hrdata_reg;
  logic         hready_reg;
  logic         standby_s;
  logic         fifo_valid;
  sssf_rxw_t    fifo_word;

  function automatic logic [4:0] clr_mask(input logic [4:0] armed,
                                          input logic [4:0] wbits);
    clr_mask = armed & ~wbits;
  endfunction : clr_mask

  // ****************************************
  // bus decode
  // ****************************************
  wire acc     = hsel & htrans[1] & hready;
  wire in_wait = (st_reg == ST_WAIT);
  wire wr_go   = in_wait & wr_reg;
  wire rd_go   = in_wait & ~wr_reg;
  wire wr_stat = wr_go & (addr_reg == SSF_ADDR_STATUS);
  wire rd_stat = rd_go & (addr_reg == SSF_ADDR_STATUS);
  wire wr_ctrl = wr_go & (addr_reg == SSF_ADDR_CTRL);
  wire wr_txd  = wr_go & (addr_reg == SSF_ADDR_TXDATA);
  wire [4:0] clr_now = clr_mask(armed_reg, hwdata[7:3]);
  wire init    = standby_s | ctrl_reg[SSF_C_MSTOP];
  wire tx_en     = ctrl_reg[SSF_C_TXEN];
  wire rx_en     = ctrl_reg[SSF_C_RXEN];
  wire rx_irq_en = ctrl_reg[SSF_C_RXIRQEN];
  wire [31:0] rd_mux =
    (addr_reg == SSF_ADDR_STATUS) ? {24'h000000, stat_reg} :
    (addr_reg == SSF_ADDR_CTRL)   ? {28'h0000000, ctrl_reg} :
    (addr_reg == SSF_ADDR_TXDATA) ? {24'h000000, tx_hold_reg} :
    (addr_reg == SSF_ADDR_RXDATA) ? {24'h000000, rx_hold_reg} : 32'h00000000;

  // ****************************************
  // receive drain
  // ****************************************
  // fifo holds words while receive is off, so disabling never drops data
  wire drain   = fifo_valid & rx_en;
  wire ovr_go  = drain & stat_reg[SSF_B_RXFULL];
  wire err_go  = drain & ~stat_reg[SSF_B_RXFULL] & (fifo_word.ferr | fifo_word.perr);
  wire load_go = drain & ~stat_reg[SSF_B_RXFULL] & ~fifo_word.ferr & ~fifo_word.perr;

  sssf_fifo #(.W($bits(sssf_rxw_t)), .D(SSF_FIFO_DEPTH)) u_rx_fifo (
    .clk       (hclk),
    .rstn      (hresetn),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_word),
    .out_valid (fifo_valid),
    .out_ready (rx_en),
    .out_data  (fifo_word)
  );

  sssf_sync3 u_stby (
    .clk  (hclk),
    .rstn (hresetn),
    .d    (standby_pin),
    .q    (standby_s)
  );

  // ****************************************
  // bus sequencing
  // ****************************************
  // one wait state on every access keeps hrdata a flop
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: if (acc) st_next = ST_WAIT;
      ST_WAIT: st_next = ST_DONE;
      ST_DONE: st_next = acc ? ST_WAIT : ST_IDLE;
    endcase
  end

  // ****************************************
  // status next value
  // ****************************************
  always_comb begin
    stat_next  = stat_reg;
    armed_next = armed_reg;
    if (rd_stat) armed_next = armed_reg | stat_reg[7:3];
    if (wr_stat) begin
      stat_next[7:3] = stat_reg[7:3] & ~clr_now;
      armed_next     = 5'h00;
      stat_next[SSF_B_TXMP] = hwdata[SSF_B_TXMP];
    end
    if (xfer_tx_write) stat_next[SSF_B_TXEMPTY] = 1'h0;
    if (xfer_rx_read) stat_next[SSF_B_RXFULL] = 1'h0;
    if (!tx_en || tx_load) stat_next[SSF_B_TXEMPTY] = 1'h1;
    if (load_go) begin
      stat_next[SSF_B_RXFULL] = 1'h1;
      stat_next[SSF_B_RXMP]   = fifo_word.mp_bit;
    end
    if (ovr_go) stat_next[SSF_B_OVERRUN] = 1'h1;
    // error set builds on the cleared value so a same-cycle clear of the other flag holds
    if (err_go) begin
      stat_next[SSF_B_FRAMING] = stat_next[SSF_B_FRAMING] | fifo_word.ferr;
      stat_next[SSF_B_PARITY]  = stat_next[SSF_B_PARITY] | fifo_word.perr;
    end
    stat_next[SSF_B_TXEND] = tx_end_in;
    if (init) begin
      stat_next  = SSF_STATUS_RST;
      armed_next = 5'h00;
    end
  end

  // ****************************************
  // flops
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg     <= ST_IDLE;
      addr_reg   <= 8'h00;
      wr_reg     <= 1'h0;
      hready_reg <= 1'h1;
      hrdata_reg <= 32'h00000000;
    end else begin
      st_reg     <= st_next;
      hready_reg <= (st_next != ST_WAIT);
      if (acc) begin
        addr_reg <= haddr[7:0];
        wr_reg   <= hwrite;
      end
      if (rd_go) hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg  <= SSF_STATUS_RST;
      armed_reg <= 5'h00;
      ctrl_reg  <= SSF_CTRL_RST;
      irq_reg   <= 1'h0;
      pend_reg  <= 1'h0;
    end else begin
      stat_reg  <= stat_next;
      armed_reg <= armed_next;
      if (wr_ctrl) ctrl_reg <= hwdata[3:0];
      irq_reg   <= rx_irq_en & stat_next[SSF_B_RXFULL];
      pend_reg  <= ~stat_next[SSF_B_TXEMPTY];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold_reg <= 8'h00;
      rx_hold_reg <= 8'h00;
    end else begin
      if (xfer_tx_write) tx_hold_reg <= xfer_tx_data;
      else if (wr_txd) tx_hold_reg <= hwdata[7:0];
      if (load_go) rx_hold_reg <= fifo_word.data;
    end
  end

  assign hrdata        = hrdata_reg;
  assign hreadyout     = hready_reg;
  assign hresp         = 1'h0;
  assign tx_data_o     = tx_hold_reg;
  assign tx_pending_o  = pend_reg;
  assign rx_data_o     = rx_hold_reg;
  assign rx_full_irq_o = irq_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INIT: assert property (init |=> stat_reg == SSF_STATUS_RST)
    else $error("status not initialised");
  AST_ACCESS: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("access not answered in two cycles");
  AST_NO_SET: assert property (wr_stat && !init && !drain && !stat_reg[6] |=> !stat_reg[6])
    else $error("write of one set a flag");
  AST_RO_BITS: assert property (wr_stat && !init |=> stat_reg[2] == $past(tx_end_in) && stat_reg[0] == $past(hwdata[0]))
    else $error("read-only or writable bit wrong");
  AST_EMPTY_SET: assert property ((!tx_en || tx_load) && !init |=> stat_reg[7])
    else $error("empty flag not set");
  AST_EMPTY_CLR: assert property (xfer_tx_write && tx_en && !tx_load && !init |=> !stat_reg[7] && tx_hold_reg == $past(xfer_tx_data))
    else $error("controller write did not clear empty");
  AST_FULL_SET: assert property (load_go && !init |=> stat_reg[6] && rx_hold_reg == $past(fifo_word.data))
    else $error("clean word not loaded");
  AST_FULL_CLR: assert property (xfer_rx_read && !load_go && !init |=> !stat_reg[6])
    else $error("controller read did not clear full");
  AST_ERR_KEEP: assert property ((err_go || !rx_en) && !xfer_rx_read && !wr_stat && !init |=> $stable(rx_hold_reg) && stat_reg[6] == $past(stat_reg[6]))
    else $error("error or disable touched holding");
  AST_OVERRUN: assert property (ovr_go && !init |=> stat_reg[5] && $stable(rx_hold_reg))
    else $error("overrun not flagged");
  AST_OVR_CLR: assert property (wr_stat && !hwdata[5] && armed_reg[2] && !ovr_go && !init |=> !stat_reg[5])
    else $error("overrun not cleared");
  AST_IRQ: assert property (load_go && rx_irq_en && !init |=> rx_full_irq_o)
    else $error("receive request missing");
  AST_NOARM: assert property (wr_stat && !armed_reg[4] && stat_reg[7] && !xfer_tx_write && !init |=> stat_reg[7])
    else $error("unarmed flag cleared");

  COV_OVERRUN: cover property (ovr_go);
  COV_RX_XFER: cover property (load_go ##[1:20] xfer_rx_read);
  COV_SW_CLEAR: cover property (rd_stat ##[1:10] (wr_stat && |clr_now));
endmodule : sssf_core

/* File: sssf_line_model.sv */
`timescale 1ns/1ps
module sssf_line_model
  import sssf_pkg::*;
(
  input  wire logic hclk,      // clock
  input  wire logic rx_ready,  // fifo can take a word
  output logic      rx_valid,  // word offered
  output sssf_rxw_t rx_word,   // offered word with error bits
  output logic      tx_load,   // holding moved to shift register
  output logic      tx_end_in  // transmitter idle level
);
  initial begin
    rx_valid  = 1'b0;
    rx_word   = '0;
    tx_load   = 1'b0;
    tx_end_in = 1'b1;
  end

  task automatic send(input sssf_rxw_t w, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_word  <= w;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge hclk);
      ok = rx_ready;
    end
    rx_valid <= 1'b0;
    // a released word flips so a stale copy cannot be mistaken for data
    rx_word  <= ~w;
  endtask : send

  task automatic load;
    @(posedge hclk);
    tx_load   <= 1'b1;
    tx_end_in <= 1'b0;
    @(posedge hclk);
    tx_load <= 1'b0;
    repeat (3) @(posedge hclk);
    tx_end_in <= 1'b1;
  endtask : load
endmodule : sssf_line_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
  import sssf_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hreadyout, hresp, standby_pin;
  logic        xfer_tx_write, xfer_rx_read, rx_valid, rx_ready, tx_load, tx_end_in;
  logic        tx_pending_o, rx_full_irq_o, ok, fm;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  xfer_tx_data, tx_data_o, rx_data_o, d;
  sssf_rxw_t   rx_word, w;
  logic [7:0]  q[$];
  int          err_count, compares, m, i;

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  sssf_core u_sssf_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .standby_pin(standby_pin), .tx_load(tx_load),
    .tx_end_in(tx_end_in), .tx_data_o(tx_data_o), .tx_pending_o(tx_pending_o),
    .xfer_tx_write(xfer_tx_write), .xfer_tx_data(xfer_tx_data), .xfer_rx_read(xfer_rx_read),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .rx_data_o(rx_data_o),
    .rx_full_irq_o(rx_full_irq_o));

  sssf_line_model u_line (
    .hclk(hclk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_word(rx_word),
    .tx_load(tx_load), .tx_end_in(tx_end_in));

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic final_report;
    $display("checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one access; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 80);
    rd = hrdata;
    if (n >= 80) begin
      err_count++;
      final_report();
    end
  endtask : ahb

  task automatic rs;
    ahb(1'b0, SSF_ADDR_STATUS, 32'h0);
    chk("status", m, rd);
  endtask : rs

  function automatic sssf_rxw_t rw(input logic f, input logic p);
    sssf_rxw_t r;
    {r.mp_bit, r.data} = 9'($urandom);
    r.ferr = f;
    r.perr = p;
    return r;
  endfunction : rw

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {hresetn, hsel, hwrite, htrans, standby_pin, xfer_tx_write, xfer_rx_read} = '0;
    {haddr, hwdata, xfer_tx_data} = '0;
    hsize = 3'h2;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h472e1528));
    m = 8'h84;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'hFF);
    m = 8'h85;
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'h0);
    m = 8'h84;
    rs();
    ahb(1'b1, SSF_ADDR_CTRL, 32'h1);
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'h0);
    m = 8'h04;
    rs();
    u_line.load();
    m = 8'h84;
    rs();
    d = 8'($urandom);
    @(posedge hclk);
    xfer_tx_write <= 1'b1;
    xfer_tx_data  <= d;
    @(posedge hclk);
    xfer_tx_write <= 1'b0;
    repeat (2) @(posedge hclk);
    m = 8'h04;
    rs();
    chk("tx_data_o", d, tx_data_o);
    chk("tx_pending_o", 1, tx_pending_o);
    ahb(1'b1, SSF_ADDR_CTRL, 32'h0);
    m = 8'h84;
    rs();
    ahb(1'b1, SSF_ADDR_CTRL, 32'h7);
    w = rw(1'b0, 1'b0);
    u_line.send(w, ok);
    q.push_back(w.data);
    repeat (5) @(posedge hclk);
    m = 8'hC4 + 2 * w.mp_bit;
    rs();
    chk("rx_full_irq_o", 1, rx_full_irq_o);
    u_line.send(rw(1'b0, 1'b0), ok);
    repeat (5) @(posedge hclk);
    m = m | 8'h20;
    rs();
    chk("rx_data_o", q[0], rx_data_o);
    @(posedge hclk);
    xfer_rx_read <= 1'b1;
    @(posedge hclk);
    xfer_rx_read <= 1'b0;
    repeat (2) @(posedge hclk);
    m = m & 8'hBF;
    chk("rx_full_irq_o", 0, rx_full_irq_o);
    u_line.send(rw(1'b1, 1'b0), ok);
    u_line.send(rw(1'b0, 1'b1), ok);
    repeat (5) @(posedge hclk);
    m = m | 8'h18;
    rs();
    chk("rx_data_o", q[0], rx_data_o);
    ahb(1'b1, SSF_ADDR_STATUS, 32'hFF);
    ahb(1'b1, SSF_ADDR_STATUS, 32'h0);
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'h0);
    m = m & 8'h07;
    rs();
    q.delete();
    w = rw(1'b0, 1'b0);
    u_line.send(w, ok);
    q.push_back(w.data);
    repeat (5) @(posedge hclk);
    m = 8'h44 + 2 * w.mp_bit;
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'h0);
    m = m & 8'h07;
    rs();
    // receiver off: the fifo must fill and then refuse
    ahb(1'b1, SSF_ADDR_CTRL, 32'h1);
    for (i = 0; i < SSF_FIFO_DEPTH; i++) begin
      w = rw(1'b0, 1'b0);
      if (i == 0) fm = w.mp_bit;
      u_line.send(w, ok);
      q.push_back(w.data);
      chk("rx_accept", 1, ok);
    end
    u_line.send(rw(1'b0, 1'b0), ok);
    chk("rx_refuse", 0, ok);
    rs();
    chk("rx_data_o", q[0], rx_data_o);
    ahb(1'b1, SSF_ADDR_CTRL, 32'h7);
    repeat (14) @(posedge hclk);
    q.pop_front();
    m = 8'h64 + 2 * fm;
    rs();
    chk("rx_data_o", q[0], rx_data_o);
    chk("rx_ready", 1, rx_ready);
    ahb(1'b1, SSF_ADDR_CTRL, 32'h9);
    m = 8'h84;
    rs();
    ahb(1'b1, SSF_ADDR_CTRL, 32'h1);
    rs();
    ahb(1'b1, SSF_ADDR_STATUS, 32'h1);
    m = 8'h05;
    rs();
    standby_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    standby_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    m = 8'h84;
    rs();
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, hresp);
    final_report();
  end
endmodule : testbench
